// File: rtl/serial_shift_unit_two_wire.sv
`timescale 1ns/10ps
// What this block does
// - bus pins are plain open-drain levels, no slew limit or glitch filter
// - external master makes the clock; this unit holds it as slave or toggles it via the port bit
// - each shift clock event advances 4-bit counter with the shift register; external clock also counts the other edge
// - start detection sets the start condition flag
// - after start, hold clock low from next falling edge until flag cleared
// - sample data on rising clock edge, shift into shift data register
// - counter overflow after eight bits forces clock low in wire mode 11
// - addressed slave drives data low for acknowledge; software presets counter 14
// - direction bit one means slave drives data, else master drives
// - bytes after addressing all flow one way until stop or restart
// - slave withholds acknowledge when full; reading master ends via acknowledge
// - start detector enabled in two-wire mode only, data delayed vs clock
// - start detector runs without the system clock
// - bus clock at most half the system clock
// - in two-wire slave use clock held low until slave ready
// - counter usable alone; external clock counts both edges
// - counter preset F with external source overflows on next pin edge
// - control register layout, bits 1:0 write-only, all reset zero
// - start flag and start enable and global enable raise interrupt
// - overflow flag and overflow enable and global enable raise interrupt
// - wire mode 00 off, 01 three-wire, 10 two-wire, 11 adds overflow hold
// - two-wire data pulled low when top bit or port bit is zero

// ------------------------------------------------------------
// link side: rising-edge data capture
// ------------------------------------------------------------
module link_bit_capture (
   input wire logic scl_clk_in,
   input wire logic arst_n_in,
   input wire logic sda_in,
   output logic bit_out,
   output logic tgl_out
);
   import serial_unit_pkg::*;
   link_state_t q, d;

   always_comb begin
      d = q;
      d.bit_val = sda_in;
      d.tgl = ~q.tgl;
   end

   always_ff @(posedge scl_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign bit_out = q.bit_val;
   assign tgl_out = q.tgl;
endmodule // link_bit_capture

// ------------------------------------------------------------
// start detector, clocked by the data line itself
// ------------------------------------------------------------
module start_catch (
   input wire logic sda_in,
   input wire logic scl_clk_in,
   input wire logic arst_n_in,
   output logic tgl_out
);
   import serial_unit_pkg::*;
   start_state_t q, d;

   always_comb begin
      d = q;
      if (scl_clk_in) begin
         d.tgl = ~q.tgl;
      end
   end

   // the pad delays data against clock, so clock level is settled here
   always_ff @(negedge sda_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tgl_out = q.tgl;
endmodule // start_catch

// ------------------------------------------------------------
// top
// ------------------------------------------------------------
module serial_shift_unit_two_wire
   import serial_unit_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   input wire logic scl_clk_in,
   input wire logic sda_in,
   input wire logic [ADDR_W-1:0] io_addr_in,
   input wire logic io_wr_in,
   input wire logic io_rd_in,
   input wire logic [7:0] io_wdata_in,
   input wire logic timer_match_in,
   input wire logic global_irq_enable_in,
   output logic [7:0] io_rdata_out,
   output logic sda_out,
   output logic sda_oe_n_out,
   output logic scl_out,
   output logic scl_oe_n_out,
   output logic start_irq_out,
   output logic overflow_irq_out
);

   typedef struct packed {
      pin_pair_t s1;
      pin_pair_t s2;
      logic scl_prev;
      logic rise_s1;
      logic rise_s2;
      logic rise_prev;
      logic bit_s1;
      logic bit_s2;
      logic start_s1;
      logic start_s2;
      logic start_prev;
      ctl_t ctl;
      logic start_flag;
      logic ovf_flag;
      logic start_hold;
      logic [3:0] cnt;
      logic [7:0] data;
      logic [3:0] port;
      logic do_latch;
      logic sda_oe_n;
      logic scl_oe_n;
      logic start_irq;
      logic ovf_irq;
      logic drive_zero;
      logic [7:0] rdata;
   } sys_state_t;

   sys_state_t q, d;
   logic link_bit, link_tgl, start_tgl;
   logic wr_ctl, wr_stat, wr_data, wr_port;
   logic two_wire, ext_src, ext_shift, scl_fall, rise_evt, start_evt;
   logic shift_evt, count_evt, shift_bit, scl_low, sda_low;

   link_bit_capture u_link (
      .scl_clk_in(scl_clk_in),
      .arst_n_in(arst_n_in),
      .sda_in(sda_in),
      .bit_out(link_bit),
      .tgl_out(link_tgl)
   );

   start_catch u_start (
      .sda_in(sda_in),
      .scl_clk_in(scl_clk_in),
      .arst_n_in(arst_n_in),
      .tgl_out(start_tgl)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      d = q;
      // two flops on every pin level, no filtering; bus clock must stay under half sys clock
      d.s1.scl = scl_clk_in;
      d.s1.sda = sda_in;
      d.s2 = q.s1;
      d.scl_prev = q.s2.scl;
      d.rise_s1 = link_tgl;
      d.rise_s2 = q.rise_s1;
      d.rise_prev = q.rise_s2;
      d.bit_s1 = link_bit;
      d.bit_s2 = q.bit_s1;
      d.start_s1 = start_tgl;
      d.start_s2 = q.start_s1;
      d.start_prev = q.start_s2;

      wr_ctl = io_wr_in && (io_addr_in == CTL_ADDR);
      wr_stat = io_wr_in && (io_addr_in == STAT_ADDR);
      wr_data = io_wr_in && (io_addr_in == DATA_ADDR);
      wr_port = io_wr_in && (io_addr_in == PORT_ADDR);

      two_wire = q.ctl.wire_mode[1];
      ext_src = q.ctl.clock_source[1];
      ext_shift = ext_src && !q.ctl.clock_strobe_select;
      scl_fall = q.scl_prev && !q.s2.scl;
      rise_evt = q.rise_s2 ^ q.rise_prev;
      start_evt = q.start_s2 ^ q.start_prev;

      // rising edge data from link capture, falling mode uses synced pin
      shift_bit = (ext_src && !q.ctl.clock_source[0]) ? q.bit_s2 : q.s2.sda;
      shift_evt = (ext_shift && (q.ctl.clock_source[0] ? scl_fall : rise_evt))
                  || (q.ctl.clock_source == CS_TIMER && timer_match_in)
                  || (q.ctl.clock_source == CS_SOFT && wr_ctl && io_wdata_in[CTL_STROBE]);
      count_evt = (ext_shift && (scl_fall || rise_evt))
                  || (q.ctl.clock_source == CS_TIMER && timer_match_in)
                  || (q.ctl.clock_source == CS_SOFT && wr_ctl && io_wdata_in[CTL_STROBE])
                  || (ext_src && wr_ctl && io_wdata_in[CTL_STROBE] && io_wdata_in[CTL_TOGGLE]);

      // control register, strobe bits never stored as readable
      if (wr_ctl) begin
         d.ctl.start_irq_enable = io_wdata_in[CTL_SIE];
         d.ctl.overflow_irq_enable = io_wdata_in[CTL_OIE];
         d.ctl.wire_mode = io_wdata_in[CTL_WM_HI:CTL_WM_LO];
         d.ctl.clock_source = io_wdata_in[CTL_CS_HI:CTL_CS_LO];
         d.ctl.clock_strobe_select = io_wdata_in[CTL_STROBE];
      end

      if (wr_stat && io_wdata_in[STAT_START]) begin
         d.start_flag = 1'b0;
      end
      if (wr_stat && io_wdata_in[STAT_OVF]) begin
         d.ovf_flag = 1'b0;
      end

      if (count_evt) begin
         d.cnt = q.cnt + 4'h1;
         // preset F overflows on next event
         if (q.cnt == CNT_MAX) begin
            d.ovf_flag = 1'b1;
         end
      end
      // software preset, such as 14, wins over a same-cycle count
      if (wr_stat) begin
         d.cnt = io_wdata_in[3:0];
      end

      // start sets flag, set beats clear
      if (start_evt && two_wire) begin
         d.start_flag = 1'b1;
      end

      // hold begins at first falling clock edge after start
      if (q.start_flag && scl_fall && two_wire) begin
         d.start_hold = 1'b1;
      end
      if (!d.start_flag) begin
         d.start_hold = 1'b0;
      end

      if (shift_evt) begin
         d.data = {q.data[6:0], shift_bit};
      end
      if (wr_data) begin
         d.data = io_wdata_in;
      end

      // output latch is open in the phase before the shifting edge, so an ack write shows while clock is held
      if (!ext_src) begin
         d.do_latch = d.data[7];
      end else if (q.ctl.clock_source[0] ? q.s2.scl : !q.s2.scl) begin
         d.do_latch = d.data[7];
      end

      if (wr_port) begin
         d.port = io_wdata_in[3:0];
      end
      // master clock comes from toggling the port bit
      if (wr_ctl && io_wdata_in[CTL_TOGGLE]) begin
         d.port[PORT_SCL_OUT] = ~q.port[PORT_SCL_OUT];
      end

      // overflow hold only in mode 11
      scl_low = two_wire && q.port[PORT_SCL_DIR]
                && (!q.port[PORT_SCL_OUT] || q.start_hold
                    || (q.ctl.wire_mode == WM_TWO_HOLD && q.ovf_flag));
      // open-drain data, low when top bit or port bit zero
      sda_low = two_wire && q.port[PORT_SDA_DIR]
                && (!q.do_latch || !q.port[PORT_SDA_OUT]);
      d.scl_oe_n = !scl_low;
      d.sda_oe_n = !sda_low;

      d.start_irq = q.start_flag && q.ctl.start_irq_enable && global_irq_enable_in;
      d.ovf_irq = q.ovf_flag && q.ctl.overflow_irq_enable && global_irq_enable_in;

      if (io_rd_in) begin
         case (io_addr_in)
            CTL_ADDR: begin
               d.rdata = {q.ctl.start_irq_enable, q.ctl.overflow_irq_enable,
                          q.ctl.wire_mode, q.ctl.clock_source, 2'h0};
            end
            STAT_ADDR: begin
               d.rdata = {q.start_flag, q.ovf_flag, 2'h0, q.cnt};
            end
            DATA_ADDR: begin
               d.rdata = q.data;
            end
            PORT_ADDR: begin
               d.rdata = {4'h0, q.port};
            end
            default: begin
               d.rdata = 8'h00;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         q <= '0;
         q.ctl <= ctl_t'(CTL_RESET[7:1]);
         q.port <= PORT_RESET;
         q.do_latch <= 1'b1;
         q.sda_oe_n <= 1'b1;
         q.scl_oe_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // open-drain pins only ever pull low
   assign sda_out = q.drive_zero;
   assign scl_out = q.drive_zero;
   assign sda_oe_n_out = q.sda_oe_n;
   assign scl_oe_n_out = q.scl_oe_n;
   assign start_irq_out = q.start_irq;
   assign overflow_irq_out = q.ovf_irq;
   assign io_rdata_out = q.rdata;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!arst_n_in);

   ovf_flag_set_a: assert property (count_evt && q.cnt == CNT_MAX |=> q.ovf_flag)
      else $error("overflow flag missed");
   cnt_step_a: assert property (count_evt && !wr_stat |=> q.cnt == $past(q.cnt) + 4'h1)
      else $error("counter did not advance");
   start_flag_a: assert property (start_evt && two_wire |=> q.start_flag)
      else $error("start flag not set");
   start_gate_a: assert property (start_evt && !two_wire && !q.start_flag |=> !q.start_flag)
      else $error("start flag set outside two-wire mode");
   hold_release_a: assert property (wr_stat && io_wdata_in[STAT_START] && !start_evt
                                    && q.port[PORT_SCL_OUT] && q.ctl.wire_mode != WM_TWO_HOLD |=> ##1 q.scl_oe_n)
      else $error("clock not released after start flag clear");
   ovf_hold_a: assert property (q.ctl.wire_mode == WM_TWO_HOLD && q.ovf_flag
                                && q.port[PORT_SCL_DIR] |=> !q.scl_oe_n)
      else $error("overflow hold not applied");
   sda_drive_a: assert property (two_wire && q.port[PORT_SDA_DIR] && !q.port[PORT_SDA_OUT]
                                 |=> !q.sda_oe_n)
      else $error("data line not pulled low");
   w1c_keep_a: assert property (wr_stat && !io_wdata_in[STAT_OVF] && q.ovf_flag |=> q.ovf_flag)
      else $error("overflow flag lost on zero write");
   irq_ovf_a: assert property (q.ovf_flag && q.ctl.overflow_irq_enable && global_irq_enable_in
                               |=> overflow_irq_out)
      else $error("overflow interrupt missing");
   irq_start_a: assert property (!q.start_flag |=> !start_irq_out)
      else $error("start interrupt without flag");
   shift_in_a: assert property (shift_evt && !wr_data |=> q.data[0] == $past(shift_bit))
      else $error("bit not shifted in");

   start_seen_c: cover property (start_evt && two_wire ##[1:200] q.start_hold);
   byte_done_c: cover property (count_evt && q.cnt == CNT_MAX && two_wire);
   ack_preset_c: cover property (wr_stat && io_wdata_in[3:0] == ACK_PRESET);
   ovf_hold_c: cover property (q.ctl.wire_mode == WM_TWO_HOLD && !q.scl_oe_n);

endmodule // serial_shift_unit_two_wire

// File: rtl/serial_unit_pkg.sv
package serial_unit_pkg;

   // ------------------------------------------------------------
   // register port
   // ------------------------------------------------------------
   localparam int ADDR_W = 6;
   localparam logic [5:0] CTL_ADDR = 6'h0d;
   localparam logic [5:0] STAT_ADDR = 6'h0e;
   localparam logic [5:0] DATA_ADDR = 6'h0f;
   localparam logic [5:0] PORT_ADDR = 6'h10;

   // control register bit positions
   localparam int CTL_SIE = 7;
   localparam int CTL_OIE = 6;
   localparam int CTL_WM_HI = 5;
   localparam int CTL_WM_LO = 4;
   localparam int CTL_CS_HI = 3;
   localparam int CTL_CS_LO = 2;
   localparam int CTL_STROBE = 1;
   localparam int CTL_TOGGLE = 0;

   // status register bit positions
   localparam int STAT_START = 7;
   localparam int STAT_OVF = 6;

   // port register bit positions
   localparam int PORT_SDA_OUT = 0;
   localparam int PORT_SCL_OUT = 1;
   localparam int PORT_SDA_DIR = 2;
   localparam int PORT_SCL_DIR = 3;

   localparam logic [1:0] WM_OFF = 2'h0;
   localparam logic [1:0] WM_TWO_HOLD = 2'h3;
   localparam logic [1:0] CS_SOFT = 2'h0;
   localparam logic [1:0] CS_TIMER = 2'h1;
   localparam logic [3:0] CNT_MAX = 4'hf;
   localparam logic [3:0] ACK_PRESET = 4'he;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [3:0] PORT_RESET = 4'h0;

   typedef struct packed {
      logic start_irq_enable;
      logic overflow_irq_enable;
      logic [1:0] wire_mode;
      logic [1:0] clock_source;
      logic clock_strobe_select;
   } ctl_t;

   typedef struct packed {
      logic sda;
      logic scl;
   } pin_pair_t;

   typedef struct packed {
      logic bit_val;
      logic tgl;
   } link_state_t;

   typedef struct packed {
      logic tgl;
   } start_state_t;

endpackage

// File: tb/bus_master_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// far-side bus master, behavioural
// ------------------------------------------------------------
module bus_master_model (
   input wire logic scl_line_in,
   input wire logic sda_line_in,
   output logic scl_drv_out,
   output logic sda_drv_out
);
   // half period well above one system clock period
   localparam int HALF_NS = 32;

   // released lines rest high through the pull-ups
   initial begin
      scl_drv_out = 1'b1;
      sda_drv_out = 1'b1;
   end

   // only the master moves the clock
   task automatic scl_set(input logic v);
      int n;
      n = 0;
      scl_drv_out = v;
      // confirm the line rose; bounded so a stuck hold cannot hang the run
      while (v && !scl_line_in && n < 5000) begin
         #1;
         n++;
      end
      #HALF_NS;
   endtask

   // data falls while the clock is high
   task automatic do_start();
      scl_set(1'b1);
      sda_drv_out = 1'b0;
      #HALF_NS;
   endtask

   // master drives data; a released bit lets the slave answer
   // data moves mid low phase, one bit per 64 ns clock period
   task automatic send_bit(input logic b);
      sda_drv_out = b;
      #(HALF_NS / 2);
      scl_set(1'b1);
      scl_drv_out = 1'b0;
      #(HALF_NS / 2);
   endtask
endmodule // bus_master_model

// File: tb/tb_serial_shift_unit_two_wire.sv
`timescale 1ns/10ps
module tb_serial_shift_unit_two_wire;
   import serial_unit_pkg::*;
   logic sys_clk_in, arst_n_in, io_wr_in, io_rd_in, timer_match_in, global_irq_enable_in;
   logic [ADDR_W-1:0] io_addr_in;
   logic [7:0] io_wdata_in, io_rdata_out, got;
   logic sda_out, sda_oe_n_out, scl_out, scl_oe_n_out, start_irq_out, overflow_irq_out;
   logic scl_drv, sda_drv, scl_line, sda_line;
   int error_cnt = 0;
   int compares = 0;
   int cycles = 0;

   // open-drain wires with pull-ups
   assign scl_line = scl_drv & scl_oe_n_out;
   assign sda_line = sda_drv & sda_oe_n_out;

   serial_shift_unit_two_wire DUT (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .scl_clk_in(scl_line),
      .sda_in(sda_line), .io_addr_in(io_addr_in), .io_wr_in(io_wr_in), .io_rd_in(io_rd_in),
      .io_wdata_in(io_wdata_in), .timer_match_in(timer_match_in), .global_irq_enable_in(global_irq_enable_in),
      .io_rdata_out(io_rdata_out), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .scl_out(scl_out),
      .scl_oe_n_out(scl_oe_n_out), .start_irq_out(start_irq_out), .overflow_irq_out(overflow_irq_out));

   bus_master_model master (.scl_line_in(scl_line), .sda_line_in(sda_line), .scl_drv_out(scl_drv),
      .sda_drv_out(sda_drv));

   initial begin
      sys_clk_in = 1'b0;
      forever #10 sys_clk_in = ~sys_clk_in;
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // a hung handshake ends here rather than running forever
   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         finish_test();
      end
   end

   task automatic check(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk_in);
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(negedge sys_clk_in);
      io_addr_in = a;
      io_wdata_in = d;
      io_wr_in = 1'b1;
      @(negedge sys_clk_in);
      io_wr_in = 1'b0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
      @(negedge sys_clk_in);
      io_addr_in = a;
      io_rd_in = 1'b1;
      @(negedge sys_clk_in);
      io_rd_in = 1'b0;
      d = io_rdata_out;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic test_regs();
      rd(CTL_ADDR, got);
      check(got, CTL_RESET);
      wr(CTL_ADDR, 8'hff);
      rd(CTL_ADDR, got);
      check(got, 8'hfc);
      wr(6'h3f, 8'h00);
      rd(6'h3f, got);
      check(got, 8'h00);
      rd(CTL_ADDR, got);
      check(got, 8'hfc);
      wr(CTL_ADDR, 8'h00);
      $display("test_regs done");
   endtask

   task automatic test_start();
      wr(DATA_ADDR, 8'hff);
      wr(PORT_ADDR, 8'h0f);
      wr(CTL_ADDR, 8'ha8);
      wr(STAT_ADDR, 8'hc0);
      master.do_start();
      idle(8);
      rd(STAT_ADDR, got);
      check(got & 8'h80, 8'h80);
      check({7'h0, start_irq_out}, 8'h00);
      global_irq_enable_in = 1'b1;
      idle(3);
      check({7'h0, start_irq_out}, 8'h01);
      master.scl_set(1'b0);
      idle(8);
      check({7'h0, scl_oe_n_out}, 8'h00);
      wr(STAT_ADDR, 8'h00);
      idle(4);
      rd(STAT_ADDR, got);
      check(got & 8'h80, 8'h80);
      check({7'h0, scl_oe_n_out}, 8'h00);
      wr(STAT_ADDR, 8'h80);
      idle(4);
      check({7'h0, scl_oe_n_out}, 8'h01);
      check({7'h0, start_irq_out}, 8'h00);
      $display("test_start done");
   endtask

   task automatic test_byte();
      logic [7:0] addr_byte;
      addr_byte = 8'ha5;
      wr(CTL_ADDR, 8'hf8);
      for (int i = 7; i >= 0; i--) master.send_bit(addr_byte[i]);
      idle(8);
      rd(STAT_ADDR, got);
      check(got, 8'h40);
      rd(DATA_ADDR, got);
      check(got, 8'ha5);
      check({7'h0, scl_oe_n_out}, 8'h00);
      check({7'h0, overflow_irq_out}, 8'h01);
      // ack: slave pulls data low for one bit
      wr(DATA_ADDR, 8'h00);
      idle(3);
      check({7'h0, sda_oe_n_out}, 8'h00);
      check({6'h0, sda_out, scl_out}, 8'h00);
      wr(STAT_ADDR, 8'h4e);
      idle(4);
      check({7'h0, scl_oe_n_out}, 8'h01);
      master.send_bit(1'b1);
      idle(8);
      rd(STAT_ADDR, got);
      check(got, 8'h40);
      wr(STAT_ADDR, 8'h40);
      idle(4);
      check({7'h0, scl_oe_n_out}, 8'h01);
      $display("test_byte done");
   endtask

   task automatic test_counter();
      wr(CTL_ADDR, 8'h08);
      wr(DATA_ADDR, 8'hff);
      master.scl_set(1'b1);
      // let the pin edge reach the counter before the preset
      idle(4);
      wr(STAT_ADDR, 8'hce);
      master.do_start();
      idle(6);
      rd(STAT_ADDR, got);
      check(got, 8'h0e);
      master.scl_set(1'b0);
      idle(8);
      rd(STAT_ADDR, got);
      check(got, 8'h0f);
      master.scl_set(1'b1);
      idle(8);
      rd(STAT_ADDR, got);
      check(got, 8'h40);
      check({7'h0, scl_oe_n_out}, 8'h01);
      wr(CTL_ADDR, 8'h44);
      wr(STAT_ADDR, 8'h4e);
      repeat (2) begin
         @(negedge sys_clk_in) timer_match_in = 1'b1;
         @(negedge sys_clk_in) timer_match_in = 1'b0;
      end
      idle(3);
      check({7'h0, overflow_irq_out}, 8'h01);
      wr(STAT_ADDR, 8'h4f);
      // strobe decodes against the stored source, so select software first
      wr(CTL_ADDR, 8'h00);
      wr(CTL_ADDR, 8'h02);
      idle(3);
      rd(STAT_ADDR, got);
      check(got, 8'h40);
      $display("test_counter done");
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      io_addr_in = '0;
      io_wdata_in = 8'h00;
      io_wr_in = 1'b0;
      io_rd_in = 1'b0;
      timer_match_in = 1'b0;
      global_irq_enable_in = 1'b0;
      arst_n_in = 1'b0;
      idle(20);
      arst_n_in = 1'b1;
      test_regs();
      test_start();
      test_byte();
      test_counter();
      finish_test();
   end
endmodule // tb_serial_shift_unit_two_wire
